// File: core/sdct_dev.sv
`timescale 1ns/100ps
`default_nettype none
module sdct_dev #(
    parameter int MEM_ROW_W = 2,
    parameter int MEM_COL_W = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Memory link
    sdct_link_if.dev link,
    // Status
    output logic [sdct_pkg::NB-1:0] bank_open_o,
    output logic sr_active_o,
    output logic cmd_err_o
);
    localparam int IDX_W = sdct_pkg::BA_W + MEM_ROW_W + MEM_COL_W;

    // ==========================================================
    // Command decode
    // ==========================================================
    logic cke_d_reg;
    logic sr_reg;
    logic [3:0] rc_reg;
    logic [2:0] cl_reg;
    logic dqm_d_reg;
    logic err_reg;
    logic [1:0] pv_reg;
    logic [sdct_pkg::DQ_W-1:0] pd0_reg;
    logic [sdct_pkg::DQ_W-1:0] pd1_reg;
    logic [sdct_pkg::DQ_W-1:0] dq_reg;
    logic oe_reg;
    logic open_reg [sdct_pkg::NB];
    logic [sdct_pkg::ADDR_W-1:0] row_reg [sdct_pkg::NB];
    logic [3:0] wr_reg [sdct_pkg::NB];
    logic [sdct_pkg::DQ_W-1:0] mem [2**IDX_W];

    sdct_pkg::sdct_cmd_t cmd;
    logic cmd_ok;
    logic is_act;
    logic is_rd;
    logic is_wr;
    logic is_pre;
    logic is_ref;
    logic is_mrs;
    logic sr_entry;
    logic sel_open;
    logic [IDX_W-1:0] idx;

    assign cmd = sdct_pkg::sdct_cmd_t'({link.ras_n, link.cas_n, link.we_n});
    assign cmd_ok = cke_d_reg & ~link.cs_n & ~sr_reg;
    assign is_act = cmd_ok && cmd == sdct_pkg::CMD_ACT;
    assign is_rd = cmd_ok && cmd == sdct_pkg::CMD_RD;
    assign is_wr = cmd_ok && cmd == sdct_pkg::CMD_WR;
    assign is_pre = cmd_ok && cmd == sdct_pkg::CMD_PRE;
    assign is_ref = cmd_ok && link.cke && cmd == sdct_pkg::CMD_REF;
    assign is_mrs = cmd_ok && cmd == sdct_pkg::CMD_MRS;
    assign sr_entry = cke_d_reg && !link.cke && !link.cs_n && !sr_reg
        && cmd == sdct_pkg::CMD_REF;
    assign sel_open = open_reg[link.ba];
    assign idx = {link.ba, row_reg[link.ba][MEM_ROW_W-1:0],
        link.addr[MEM_COL_W-1:0]};

    // ==========================================================
    // Power state and mode
    // ==========================================================
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cke_d_reg <= 1'b0;
            sr_reg <= 1'b0;
            rc_reg <= 4'h0;
        end else begin
            cke_d_reg <= link.cke;
            if (sr_entry) begin
                sr_reg <= 1'b1;
            end else if (sr_reg && cke_d_reg && link.cke) begin
                // Exit on the second edge with clock enable high
                sr_reg <= 1'b0;
                rc_reg <= 4'(sdct_pkg::RC_CYC);
            end else if (is_ref) begin
                rc_reg <= 4'(sdct_pkg::RC_CYC);
            end else if (rc_reg != 4'h0) begin
                rc_reg <= rc_reg - 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            cl_reg <= sdct_pkg::CL_RESET;
        end else if (is_mrs) begin
            cl_reg <= link.addr[sdct_pkg::MODE_CL_LSB +: 3];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= ((is_rd || is_wr) && !sel_open)
                || (is_act && sel_open)
                || (cmd_ok && cmd != sdct_pkg::CMD_NOP && rc_reg != 4'h0);
        end
    end

    // ==========================================================
    // Banks
    // ==========================================================
    for (genvar b = 0; b < sdct_pkg::NB; b++) begin : g_bank
        logic hit;
        assign hit = link.ba == sdct_pkg::BA_W'(b);
        assign bank_open_o[b] = open_reg[b];
        always_ff @(posedge sys_clk_i) begin
            if (!rst_n_i) begin
                open_reg[b] <= 1'b0;
                row_reg[b] <= '0;
                wr_reg[b] <= 4'h0;
            end else if (is_act && hit) begin
                open_reg[b] <= 1'b1;
                row_reg[b] <= link.addr;
                wr_reg[b] <= 4'h0;
            end else if (is_pre && (link.addr[sdct_pkg::AP_BIT] || hit)) begin
                open_reg[b] <= 1'b0;
            end else if (is_rd && hit && link.addr[sdct_pkg::AP_BIT]) begin
                open_reg[b] <= 1'b0;
            end else if (is_wr && hit && link.addr[sdct_pkg::AP_BIT]) begin
                // Internal precharge only after write recovery
                wr_reg[b] <= 4'(sdct_pkg::WR_CYC);
            end else if (wr_reg[b] == 4'h1) begin
                open_reg[b] <= 1'b0;
                wr_reg[b] <= 4'h0;
            end else if (wr_reg[b] != 4'h0) begin
                wr_reg[b] <= wr_reg[b] - 4'h1;
            end
        end
    end

    // ==========================================================
    // Data path
    // ==========================================================
    always_ff @(posedge sys_clk_i) begin
        // Mask blocks the word on its own edge; every clock takes a column
        if (is_wr && sel_open && !link.dqm) begin
            mem[idx] <= link.dq;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            pv_reg <= 2'h0;
            pd0_reg <= '0;
            pd1_reg <= '0;
            dqm_d_reg <= 1'b0;
            dq_reg <= '0;
            oe_reg <= 1'b0;
        end else begin
            pv_reg <= {pv_reg[0], is_rd && sel_open};
            pd0_reg <= mem[idx];
            pd1_reg <= pd0_reg;
            dqm_d_reg <= link.dqm;
            // Mask seen now turns the drivers off two clocks on
            if (cl_reg == 3'h3) begin
                dq_reg <= pd1_reg;
                oe_reg <= pv_reg[1] && !dqm_d_reg;
            end else begin
                dq_reg <= pd0_reg;
                oe_reg <= pv_reg[0] && !dqm_d_reg;
            end
        end
    end

    assign link.dev_dq = dq_reg;
    assign link.dev_dq_oe = oe_reg;
    assign sr_active_o = sr_reg;
    assign cmd_err_o = err_reg;

endmodule
`default_nettype wire

// File: core/sdct_host.sv
// Contract
// - Clock within grade limit per CAS latency
// - Activate to column waits row-to-column delay
// - Precharge interval passes before reactivating bank
// - Activates to different banks spaced apart
// - Column commands may follow every clock
// - Explicit precharge waits after last write
// - Auto precharge starts after write recovery
// - Write auto precharge to activate waits
// - 8192 refreshes within every 64 ms
// - Nanoseconds become cycles, rounded up
// - Ten clocks held after self-refresh exit
// - Self-refresh exit on second edge
// - Row cycle time after self-refresh exit
// - All banks idle before self-refresh
// - Read mask disables drivers two clocks later
// - Write mask acts on same edge
// - Two clocks after mode register set
// - Precharge encoding; address bit selects all
`timescale 1ns/100ps
`default_nettype none
module sdct_host (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Memory link
    sdct_link_if.host link,
    // Request
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_we_i,
    input wire logic [24:0] req_addr_i,
    input wire logic [sdct_pkg::DQ_W-1:0] req_wdata_i,
    input wire logic req_mask_i,
    // Read data
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [sdct_pkg::DQ_W-1:0] rd_data_o,
    // Power and status
    input wire logic sr_req_i,
    output logic sr_active_o,
    output logic init_done_o
);
    typedef enum logic [3:0] {
        ST_PWRUP,
        ST_PREA,
        ST_MRS,
        ST_IDLE,
        ST_ACT,
        ST_COL,
        ST_SR,
        ST_WAIT
    } sdct_state_t;

    // ==========================================================
    // State
    // ==========================================================
    sdct_state_t st_reg;
    sdct_state_t nxt_reg;
    logic [7:0] tmr_reg;
    logic cke_reg;
    logic cs_n_reg;
    sdct_pkg::sdct_cmd_t cmd_reg;
    logic [sdct_pkg::BA_W-1:0] ba_reg;
    logic [sdct_pkg::ADDR_W-1:0] addr_reg;
    logic [sdct_pkg::DQ_W-1:0] dq_reg;
    logic dq_oe_reg;
    logic dqm_reg;
    logic ready_reg;
    logic sr_reg;
    logic done_reg;
    logic rd_issue_reg;
    logic ref_ack_reg;
    logic lat_we_reg;
    logic [24:0] lat_addr_reg;
    logic [sdct_pkg::DQ_W-1:0] lat_data_reg;
    logic lat_mask_reg;
    logic [2:0] rd_sh_reg;
    logic [7:0] ref_cnt_reg;
    logic ref_due_reg;
    logic out_v_reg;
    logic [sdct_pkg::DQ_W-1:0] out_d_reg;
    logic sp_v_reg;
    logic [sdct_pkg::DQ_W-1:0] sp_d_reg;
    logic push;
    logic pop;

    // Clock of 25 MHz stays under the CAS latency 2 limit
    localparam int CLK_MHZ = 1000000 / sdct_pkg::CLK_PS;

    // ==========================================================
    // Command sequencer
    // ==========================================================
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st_reg <= ST_PWRUP;
            nxt_reg <= ST_IDLE;
            tmr_reg <= 8'(sdct_pkg::PWRUP_CYC - 1);
            cke_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            cmd_reg <= sdct_pkg::CMD_NOP;
            ba_reg <= '0;
            addr_reg <= '0;
            dq_reg <= '0;
            dq_oe_reg <= 1'b0;
            dqm_reg <= 1'b0;
            ready_reg <= 1'b0;
            sr_reg <= 1'b0;
            done_reg <= 1'b0;
            rd_issue_reg <= 1'b0;
            ref_ack_reg <= 1'b0;
            lat_we_reg <= 1'b0;
            lat_addr_reg <= '0;
            lat_data_reg <= '0;
            lat_mask_reg <= 1'b0;
        end else begin
            cs_n_reg <= 1'b1;
            cmd_reg <= sdct_pkg::CMD_NOP;
            dq_oe_reg <= 1'b0;
            dqm_reg <= 1'b0;
            ready_reg <= 1'b0;
            rd_issue_reg <= 1'b0;
            ref_ack_reg <= 1'b0;
            unique case (st_reg)
                ST_PWRUP: begin
                    if (tmr_reg == 8'h0) begin
                        st_reg <= ST_PREA;
                    end else begin
                        tmr_reg <= tmr_reg - 8'h1;
                    end
                end
                ST_PREA: begin
                    // Only precharge issued; no write precedes it
                    cs_n_reg <= 1'b0;
                    cmd_reg <= sdct_pkg::CMD_PRE;
                    addr_reg <= sdct_pkg::AP_MASK;
                    tmr_reg <= 8'(sdct_pkg::RP_CYC - 1);
                    nxt_reg <= ST_MRS;
                    st_reg <= ST_WAIT;
                end
                ST_MRS: begin
                    cs_n_reg <= 1'b0;
                    cmd_reg <= sdct_pkg::CMD_MRS;
                    ba_reg <= '0;
                    addr_reg <= sdct_pkg::MODE_WORD;
                    tmr_reg <= 8'(sdct_pkg::RSC_CYC - 1);
                    nxt_reg <= ST_IDLE;
                    done_reg <= 1'b1;
                    st_reg <= ST_WAIT;
                end
                ST_IDLE: begin
                    if (ref_due_reg) begin
                        cs_n_reg <= 1'b0;
                        cmd_reg <= sdct_pkg::CMD_REF;
                        ref_ack_reg <= 1'b1;
                        tmr_reg <= 8'(sdct_pkg::RC_CYC - 1);
                        nxt_reg <= ST_IDLE;
                        st_reg <= ST_WAIT;
                    end else if (sr_req_i) begin
                        // Every access closes its bank, so all are idle here
                        cs_n_reg <= 1'b0;
                        cmd_reg <= sdct_pkg::CMD_REF;
                        cke_reg <= 1'b0;
                        sr_reg <= 1'b1;
                        st_reg <= ST_SR;
                    end else if (req_valid_i && (req_we_i || !sp_v_reg)) begin
                        lat_we_reg <= req_we_i;
                        lat_addr_reg <= req_addr_i;
                        lat_data_reg <= req_wdata_i;
                        lat_mask_reg <= req_mask_i;
                        ready_reg <= 1'b1;
                        st_reg <= ST_ACT;
                    end
                end
                ST_ACT: begin
                    cs_n_reg <= 1'b0;
                    cmd_reg <= sdct_pkg::CMD_ACT;
                    ba_reg <= lat_addr_reg[24:23];
                    addr_reg <= lat_addr_reg[22:10];
                    // Column with precharge only after both row delays
                    tmr_reg <= 8'(sdct_pkg::ACT_GAP_CYC - 1);
                    nxt_reg <= ST_COL;
                    st_reg <= ST_WAIT;
                end
                ST_COL: begin
                    cs_n_reg <= 1'b0;
                    addr_reg <= sdct_pkg::ADDR_W'(lat_addr_reg[9:0])
                        | sdct_pkg::AP_MASK;
                    nxt_reg <= ST_IDLE;
                    st_reg <= ST_WAIT;
                    if (lat_we_reg) begin
                        cmd_reg <= sdct_pkg::CMD_WR;
                        dq_reg <= lat_data_reg;
                        dq_oe_reg <= 1'b1;
                        dqm_reg <= lat_mask_reg;
                        // Next activate only after data-in to active delay
                        tmr_reg <= 8'(sdct_pkg::DAL_CYC - 1);
                    end else begin
                        cmd_reg <= sdct_pkg::CMD_RD;
                        rd_issue_reg <= 1'b1;
                        tmr_reg <= 8'(sdct_pkg::RD_GAP_CYC - 1);
                    end
                end
                ST_SR: begin
                    if (!sr_req_i) begin
                        cke_reg <= 1'b1;
                        sr_reg <= 1'b0;
                        // Exit time of nops, then a full row cycle
                        tmr_reg <= 8'(sdct_pkg::SREX_CYC
                            + sdct_pkg::RC_CYC - 1);
                        nxt_reg <= ST_IDLE;
                        st_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (tmr_reg == 8'h0) begin
                        st_reg <= nxt_reg;
                    end else begin
                        tmr_reg <= tmr_reg - 8'h1;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Refresh interval
    // ==========================================================
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ref_cnt_reg <= 8'h0;
            ref_due_reg <= 1'b0;
        end else begin
            if (ref_cnt_reg == 8'(sdct_pkg::REF_INT_CYC - 1)) begin
                ref_cnt_reg <= 8'h0;
                ref_due_reg <= 1'b1;
            end else begin
                ref_cnt_reg <= ref_cnt_reg + 8'h1;
                if (ref_ack_reg) begin
                    ref_due_reg <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Read return and two-entry buffer
    // ==========================================================
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rd_sh_reg <= 3'h0;
        end else begin
            rd_sh_reg <= {rd_sh_reg[1:0], rd_issue_reg};
        end
    end

    assign push = rd_sh_reg[sdct_pkg::CAS_LAT - 1];
    assign pop = out_v_reg & rd_ready_i;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            out_v_reg <= 1'b0;
            out_d_reg <= '0;
            sp_v_reg <= 1'b0;
            sp_d_reg <= '0;
        end else begin
            if (pop) begin
                out_v_reg <= 1'b0;
            end
            if (sp_v_reg && (!out_v_reg || pop)) begin
                out_d_reg <= sp_d_reg;
                out_v_reg <= 1'b1;
                sp_v_reg <= push;
                sp_d_reg <= link.dq;
            end else if (push && (!out_v_reg || pop)) begin
                out_d_reg <= link.dq;
                out_v_reg <= 1'b1;
            end else if (push) begin
                sp_d_reg <= link.dq;
                sp_v_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign link.cke = cke_reg;
    assign link.cs_n = cs_n_reg;
    assign link.ras_n = cmd_reg[2];
    assign link.cas_n = cmd_reg[1];
    assign link.we_n = cmd_reg[0];
    assign link.ba = ba_reg;
    assign link.addr = addr_reg;
    assign link.dqm = dqm_reg;
    assign link.host_dq = dq_reg;
    assign link.host_dq_oe = dq_oe_reg;
    assign req_ready_o = ready_reg;
    assign rd_valid_o = out_v_reg;
    assign rd_data_o = out_d_reg;
    assign sr_active_o = sr_reg;
    assign init_done_o = done_reg;

endmodule
`default_nettype wire

// File: core/sdct_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sdct_link_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [sdct_pkg::BA_W-1:0] ba;
    logic [sdct_pkg::ADDR_W-1:0] addr;
    logic dqm;
    logic [sdct_pkg::DQ_W-1:0] host_dq;
    logic host_dq_oe;
    logic [sdct_pkg::DQ_W-1:0] dev_dq;
    logic dev_dq_oe;
    logic [sdct_pkg::DQ_W-1:0] dq;

    // Shared data wire resolved from the two enables, pulled high idle
    assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : 8'hFF);

    modport host (
        output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
        output host_dq, host_dq_oe,
        input dq
    );
    modport dev (
        input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
        output dev_dq, dev_dq_oe,
        input dq
    );
endinterface
`default_nettype wire

// File: core/sdct_pkg.sv
package sdct_pkg;

    // ==========================================================
    // Clock, grade and latency
    // ==========================================================
    localparam bit SPEED_FAST = 1'b1;
    localparam int CLK_PS = 40000;
    localparam int FMAX_CL3_MHZ = SPEED_FAST ? 166 : 133;
    localparam int FMAX_CL2_MHZ = 100;
    localparam int CAS_LAT = 2;

    // Picosecond spacing to whole cycles, fractions up, at least one
    function automatic int ps2cyc(input int ps);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int T_RCD_PS = SPEED_FAST ? 18000 : 20000;
    localparam int T_RP_PS = SPEED_FAST ? 18000 : 20000;
    localparam int T_RAS_PS = SPEED_FAST ? 42000 : 45000;
    localparam int T_RC_PS = SPEED_FAST ? 60000 : 67500;
    localparam int T_RRD_PS = SPEED_FAST ? 12000 : 15000;
    localparam int T_DPL_PS = SPEED_FAST ? 12000 : 15000;
    localparam int T_WR_PS = SPEED_FAST ? 12000 : 15000;
    localparam int RCD_CYC = ps2cyc(T_RCD_PS);
    localparam int RP_CYC = ps2cyc(T_RP_PS);
    localparam int RAS_CYC = ps2cyc(T_RAS_PS);
    localparam int RC_CYC = ps2cyc(T_RC_PS);
    localparam int RRD_CYC = ps2cyc(T_RRD_PS);
    localparam int DPL_CYC = ps2cyc(T_DPL_PS);
    localparam int WR_CYC = ps2cyc(T_WR_PS);
    localparam int DAL_CYC = SPEED_FAST ? 4 : 5;
    localparam int CCD_CYC = 1;
    localparam int SREX_CYC = 10;
    localparam int RSC_CYC = 2;
    localparam int DQZ_CYC = 2;
    localparam int DQW_CYC = 0;
    localparam int PWRUP_CYC = 8;
    localparam int REF_PERIOD_NS = 64000000;
    localparam int REF_ROWS = 8192;
    localparam int REF_INT_CYC = REF_PERIOD_NS / REF_ROWS * 1000 / CLK_PS;
    localparam int ACT_GAP_CYC = (RCD_CYC > RAS_CYC) ? RCD_CYC : RAS_CYC;
    localparam int RD_GAP_CYC = CAS_LAT + RP_CYC;

    // ==========================================================
    // Pins and commands
    // ==========================================================
    localparam int NB = 4;
    localparam int BA_W = 2;
    localparam int ADDR_W = 13;
    localparam int COL_W = 10;
    localparam int DQ_W = 8;
    localparam int AP_BIT = 10;
    localparam int MODE_CL_LSB = 4;
    localparam logic [ADDR_W-1:0] AP_MASK = 13'h0400;
    localparam logic [ADDR_W-1:0] MODE_WORD = 13'h0020;
    localparam logic [2:0] CL_RESET = 3'h2;

    typedef enum logic [2:0] {
        CMD_MRS = 3'h0,
        CMD_REF = 3'h1,
        CMD_PRE = 3'h2,
        CMD_ACT = 3'h3,
        CMD_WR = 3'h4,
        CMD_RD = 3'h5,
        CMD_BST = 3'h6,
        CMD_NOP = 3'h7
    } sdct_cmd_t;

endpackage

// File: dv/sdct_sva.sv
`timescale 1ns/100ps
`default_nettype none
module sdct_sva (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Link
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [sdct_pkg::ADDR_W-1:0] addr,
    input wire logic dqm,
    input wire logic host_dq_oe,
    input wire logic dev_dq_oe
);
    // ==========================================================
    // Command decode
    // ==========================================================
    logic sel, act, col, rd, wr, pre, mrs, cmd_v;
    logic [2:0] cmd;
    assign cmd = {ras_n, cas_n, we_n};
    assign sel = !cs_n && cke;
    assign act = sel && cmd == 3'h3;
    assign rd = sel && cmd == 3'h5;
    assign wr = sel && cmd == 3'h4;
    assign col = rd || wr;
    assign pre = sel && cmd == 3'h2;
    assign mrs = sel && cmd == 3'h0;
    assign cmd_v = sel && cmd != 3'h7;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_drive;
        dev_dq_oe ##1 !dev_dq_oe;
    endsequence
    sequence s_quiet;
        (!cmd_v)[*8] ##1 (!cmd_v)[*4];
    endsequence

    // ==========================================================
    // Assertions
    // ==========================================================
    a_col_after_act: assert property (col |-> $past(act, 3))
        else $error("column command without row open");
    a_read_latency: assert property (rd |-> ##2 s_drive)
        else $error("read data not driven at latency");
    a_dq_from_read: assert property
        (dev_dq_oe |-> $past(rd, 2) && !$past(dqm, 2))
        else $error("device drives data without read");
    a_wr_data_same: assert property (host_dq_oe == wr)
        else $error("write data not with write command");
    a_col_autopre: assert property (col |-> addr[10])
        else $error("column command without auto precharge");
    a_pre_act_gap: assert property (pre |=> !act)
        else $error("activate too soon after precharge");
    a_act_act_gap: assert property (act |=> !act)
        else $error("activates too close");
    a_dal_gap: assert property (wr |=> (!act)[*3])
        else $error("activate too soon after write");
    a_mrs_gap: assert property (mrs |=> !cmd_v)
        else $error("command too soon after mode set");
    a_sr_entry: assert property
        ($fell(cke) |-> !cs_n && cmd == 3'h1)
        else $error("clock enable dropped without refresh");
    a_sr_exit_wait: assert property ($rose(cke) |-> s_quiet)
        else $error("command during self refresh exit");
endmodule
`default_nettype wire

// File: dv/sdram_command_timing_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sdram_command_timing_tb;
    // ==========================================================
    // Harness
    // ==========================================================
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic req_valid = 1'b0;
    logic req_we = 1'b0;
    logic [24:0] req_addr = 25'h0000000;
    logic [7:0] req_wdata = 8'h00;
    logic req_mask = 1'b0;
    logic rd_ready = 1'b0;
    logic sr_req = 1'b0;
    logic err_seen = 1'b0;
    logic req_ready, rd_valid, h_sr, init_done, d_sr, cmd_err;
    logic [7:0] rd_data;
    logic [3:0] bank_open;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int refs = 0;
    sdct_link_if link ();
    always #20 sys_clk_i = ~sys_clk_i;
    sdct_host sdct_host_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .link(link.host), .req_valid_i(req_valid), .req_ready_o(req_ready),
        .req_we_i(req_we), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
        .req_mask_i(req_mask), .rd_valid_o(rd_valid), .rd_ready_i(rd_ready),
        .rd_data_o(rd_data), .sr_req_i(sr_req), .sr_active_o(h_sr),
        .init_done_o(init_done));
    sdct_dev sdct_dev_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .link(link.dev), .bank_open_o(bank_open), .sr_active_o(d_sr),
        .cmd_err_o(cmd_err));
    sdct_sva sdct_sva_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
        .cas_n(link.cas_n), .we_n(link.we_n), .addr(link.addr),
        .dqm(link.dqm), .host_dq_oe(link.host_dq_oe),
        .dev_dq_oe(link.dev_dq_oe));
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cmd_err === 1'b1) err_seen <= 1'b1;
        if ({link.cs_n, link.cke, link.ras_n, link.cas_n, link.we_n}
            === 5'h09) refs <= refs + 1;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end
    // ==========================================================
    // Transfers and scenarios
    // ==========================================================
    task automatic access(input logic we, input logic [24:0] a,
        input logic [7:0] d, input logic m);
        @(posedge sys_clk_i);
        req_valid <= 1'b1;
        req_we <= we;
        req_addr <= a;
        req_wdata <= d;
        req_mask <= m;
        @(negedge sys_clk_i);
        while (req_ready !== 1'b1) @(negedge sys_clk_i);
        @(posedge sys_clk_i);
        req_valid <= 1'b0;
    endtask
    task automatic pop(input logic [7:0] exp);
        while (rd_valid !== 1'b1) @(negedge sys_clk_i);
        check("rd_data", rd_data, exp);
        @(posedge sys_clk_i);
        rd_ready <= 1'b1;
        @(posedge sys_clk_i);
        rd_ready <= 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic t_stream();
        access(1'b1, 25'h0000001, 8'h5A, 1'b0);
        access(1'b1, 25'h1800402, 8'hC3, 1'b0);
        repeat (8) @(negedge sys_clk_i);
        check("bank_open", {4'h0, bank_open}, 8'h00);
        access(1'b0, 25'h0000001, 8'h00, 1'b0);
        access(1'b0, 25'h1800402, 8'h00, 1'b0);
        pop(8'h5A);
        pop(8'hC3);
        access(1'b1, 25'h0800005, 8'h3C, 1'b0);
        access(1'b1, 25'h0800005, 8'hE1, 1'b1);
        access(1'b0, 25'h0800005, 8'h00, 1'b0);
        pop(8'h3C);
    endtask
    task automatic t_power();
        int r0;
        r0 = refs;
        repeat (400) @(negedge sys_clk_i);
        check("refresh", {7'h00, (refs - r0) >= 400 / sdct_pkg::REF_INT_CYC},
            8'h01);
        @(posedge sys_clk_i);
        sr_req <= 1'b1;
        while (h_sr !== 1'b1) @(negedge sys_clk_i);
        @(negedge sys_clk_i);
        check("dev_sr", {7'h00, d_sr}, 8'h01);
        check("cke", {7'h00, link.cke}, 8'h00);
        @(posedge sys_clk_i);
        sr_req <= 1'b0;
        while (h_sr !== 1'b0) @(negedge sys_clk_i);
        repeat (3) @(negedge sys_clk_i);
        check("dev_sr", {7'h00, d_sr}, 8'h00);
        access(1'b0, 25'h0000001, 8'h00, 1'b0);
        pop(8'h5A);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(negedge sys_clk_i);
        check("req_ready", {7'h00, req_ready}, 8'h00);
        check("cke", {7'h00, link.cke}, 8'h01);
        while (init_done !== 1'b1) @(negedge sys_clk_i);
        check("bank_open", {4'h0, bank_open}, 8'h00);
        t_stream();
        t_power();
        check("cmd_err", {7'h00, err_seen}, 8'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
